// File: logic/ctl_chan_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CTL_CHAN_REGS_SVH
`define CTL_CHAN_REGS_SVH

`define OFS_CHAN_WDOG        8'h04
`define OFS_I2C_TIMING       8'h05
`define OFS_I2C_ERR_WDOG     8'h06
`define OFS_FAR_ADDR         8'h07
`define OFS_PASS_CTRL        8'h03

`define RST_CHAN_WDOG        8'hfe
`define RST_I2C_TIMING       8'h1e
`define RST_I2C_ERR_WDOG     8'h00
`define RST_FAR_ADDR         8'h00

`define BIT_TIMEOUT_OFF      0
`define BIT_PASS_ALL         7
`define BIT_PASS_DECODE      3
`define BIT_SEQ_ERR          7
`define BIT_SEQ_CLR          6
`define BIT_LOCAL_WR_BLOCK   2
`define BIT_BUS_WDOG_FAST    1
`define BIT_BUS_WDOG_OFF     0
`define BIT_HOLD_FAR_ADDR    0

// Clock period and time units, in ns
`define CLK_PERIOD_NS        50
`define TIMEOUT_UNIT_NS      2000000
`define HOLD_UNIT_NS         50
`define FILTER_UNIT_NS       5
`define SDA_DELAY_BASE_NS    250
`define SDA_DELAY_STEP_NS    50
`define BUS_WDOG_FAST_NS     50000
`define BUS_WDOG_SLOW_NS     1000000000
`define RECOVER_PULSES       9

`endif

// File: logic/ctl_chan_pkg.sv
// Types shared by the control channel supervision logic
package ctl_chan_pkg;

   typedef struct packed {
      logic       start;   // Transaction started on the channel
      logic       done;    // Transaction completed
      logic       seq_err; // Forward channel sequence error seen
      logic       lock;    // Receive lock
      logic [6:0] far_id;  // Identifier sent by the serializer
   } chan_status_s;

   typedef struct packed {
      logic       wr;      // Register write strobe
      logic       rd;      // Register read strobe
      logic       remote;  // Access came over the control channel
      logic [7:0] addr;    // Register offset
      logic [7:0] wdata;   // Write data
   } reg_req_s;

   typedef enum logic [1:0] {
      BUS_IDLE    = 2'b00,
      BUS_RECOVER = 2'b01,
      BUS_FREE    = 2'b10
   } bus_state_e;

endpackage

// File: logic/ctl_chan_supervisor.sv
// I2C port and control channel supervision for the deserializer
//
// Behaviour
// - Abort channel transaction not done within timeout field times 2 ms.
// - Channel watchdog runs while its disable bit is 0, halts at 1.
// - Pass-all bit forwards every local I2C transaction over the channel except to address 0 while far address is 0.
// - SDA input held after SCL by hold field times 50 ns, reset 1.
// - Reject SCL and SDA glitches up to filter field times 5 ns.
// - Read-only flag bit 7 sets on forward channel sequence error.
// - Writing clear bit 6 clears the sequence-error flag.
// - SDA output delay 250 ns plus 50 ns per step of field.
// - Block-local-write bit refuses remote writes to own registers.
// - Block-local-write does not stop remote access to local slaves.
// - Bus watchdog expires in 50 us when fast, else one second.
// - Unless disabled, SDA high and quiet for interval means bus free.
// - SDA low and quiet until expiry: drive nine SCL pulses.
// - Seven-bit far serializer address; zero disables access to it.
// - On receive lock, load far address from serializer identifier.
// - Freeze bit stops auto-load; software sets it as bit 0 of the address write.
// - Decode pass-through forwards only when address decode matches.
// - Alias-addressed transactions are remapped to physical address.
`timescale 1ns/10ps
`default_nettype none
`include "ctl_chan_regs.svh"

module ctl_chan_supervisor #(
   parameter int unsigned TIMEOUT_UNIT_CYC =
      `TIMEOUT_UNIT_NS / `CLK_PERIOD_NS,
   parameter int unsigned BUS_FAST_CYC = `BUS_WDOG_FAST_NS / `CLK_PERIOD_NS,
   parameter int unsigned BUS_SLOW_CYC = `BUS_WDOG_SLOW_NS / `CLK_PERIOD_NS,
   parameter int unsigned PULSE_HALF_CYC = 4
) (
   input  wire logic                   sys_clk,      // System clock 20 MHz
   input  wire logic                   rst_n,        // Async reset, low
   input  wire ctl_chan_pkg::reg_req_s req,          // Register access
   output logic                  [7:0] rdata,        // Register read data
   output logic                        wr_refused,   // Remote write dropped
   input  wire ctl_chan_pkg::chan_status_s chan,     // Channel status
   input  wire logic                   scl_in,       // SCL pin level
   input  wire logic                   sda_in,       // SDA pin level
   output logic                        scl_out,      // SCL drive value
   output logic                        scl_oe,       // SCL drive enable
   output logic                        sda_out,      // SDA drive value
   output logic                        sda_oe,       // SDA drive enable
   input  wire logic                   sda_drive_req, // Core wants SDA low
   input  wire logic                   txn_valid,    // Local transaction seen
   input  wire logic                   addr_match,   // Address decode hit
   input  wire logic                   alias_hit,    // Alias table hit
   input  wire logic             [6:0] alias_phys,   // Physical address
   input  wire logic             [6:0] txn_addr,     // Transaction address
   output logic                        fwd_txn,      // Forward over channel
   output logic                  [6:0] fwd_addr,     // Forwarded address
   output logic                        chan_abort,   // Transaction aborted
   output logic                        scl_filt,     // Filtered SCL
   output logic                        sda_filt,     // Held, filtered SDA
   output logic                        bus_free      // Bus watchdog: free
);

   localparam int unsigned HOLD_CYC  = `HOLD_UNIT_NS / `CLK_PERIOD_NS;
   localparam int unsigned DSTEP_CYC = `SDA_DELAY_STEP_NS / `CLK_PERIOD_NS;
   localparam int unsigned DBASE_CYC = `SDA_DELAY_BASE_NS / `CLK_PERIOD_NS;

   logic [7:0] chan_wdog;
   logic [7:0] i2c_timing;
   logic [7:0] err_wdog;
   logic [7:0] far_addr;
   logic       pass_decode;
   logic       wr_ok;

   // Remote writes are blocked only for our own registers; forwarding
   // to local slaves never goes through this path
   assign wr_ok = req.wr &&
                  !(req.remote && err_wdog[`BIT_LOCAL_WR_BLOCK]);
   assign wr_refused = req.wr && !wr_ok;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_wdog   <= `RST_CHAN_WDOG;
         i2c_timing  <= `RST_I2C_TIMING;
         pass_decode <= 1'b0;
      end else if (wr_ok) begin
         if (hit(req.addr, `OFS_CHAN_WDOG)) begin
            chan_wdog <= req.wdata;
         end
         if (hit(req.addr, `OFS_I2C_TIMING)) begin
            i2c_timing <= req.wdata;
         end
         if (hit(req.addr, `OFS_PASS_CTRL)) begin
            pass_decode <= req.wdata[`BIT_PASS_DECODE];
         end
      end
   end

   // Sequence error: set wins over a simultaneous clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_wdog <= `RST_I2C_ERR_WDOG;
      end else begin
         if (wr_ok && hit(req.addr, `OFS_I2C_ERR_WDOG)) begin
            err_wdog[4:0] <= req.wdata[4:0];
            err_wdog[`BIT_SEQ_CLR] <= req.wdata[`BIT_SEQ_CLR];
         end
         if (chan.seq_err) begin
            err_wdog[`BIT_SEQ_ERR] <= 1'b1;
         end else if (wr_ok && hit(req.addr, `OFS_I2C_ERR_WDOG) &&
                      req.wdata[`BIT_SEQ_CLR]) begin
            err_wdog[`BIT_SEQ_ERR] <= 1'b0;
         end
         err_wdog[5] <= 1'b0;
      end
   end

   // Far address: software write or auto-load on lock unless frozen
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         far_addr <= `RST_FAR_ADDR;
      end else if (wr_ok && hit(req.addr, `OFS_FAR_ADDR)) begin
         far_addr <= req.wdata;
      end else if (chan.lock && !far_addr[`BIT_HOLD_FAR_ADDR]) begin
         far_addr[7:1] <= chan.far_id;
      end
   end

   always_comb begin
      case (req.addr)
         `OFS_CHAN_WDOG:    rdata = chan_wdog;
         `OFS_I2C_TIMING:   rdata = i2c_timing;
         `OFS_I2C_ERR_WDOG: rdata = err_wdog;
         `OFS_FAR_ADDR:     rdata = far_addr;
         `OFS_PASS_CTRL:    rdata = {4'h0, pass_decode, 3'h0};
         default:           rdata = 8'h00;
      endcase
   end

   // Forwarding decision and alias remap
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fwd_txn  <= 1'b0;
         fwd_addr <= 7'h00;
      end else begin
         fwd_txn <= txn_valid &&
                    (i2c_timing[`BIT_PASS_ALL] ||
                     (pass_decode && addr_match)) &&
                    !(txn_addr == far_addr[7:1] &&
                      far_addr[7:1] == 7'h00);
         fwd_addr <= alias_hit ? alias_phys : txn_addr;
      end
   end

   // Channel watchdog
   logic [31:0] unit_cnt;
   logic [6:0]  unit_num;
   logic        txn_busy;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         txn_busy   <= 1'b0;
         unit_cnt   <= 32'h0;
         unit_num   <= 7'h00;
         chan_abort <= 1'b0;
      end else begin
         chan_abort <= 1'b0;
         if (chan.start) begin
            txn_busy <= 1'b1;
            unit_cnt <= 32'h0;
            unit_num <= 7'h00;
         end else if (chan.done || chan_wdog[`BIT_TIMEOUT_OFF]) begin
            txn_busy <= 1'b0;
            unit_cnt <= 32'h0;
            unit_num <= 7'h00;
         end else if (txn_busy) begin
            if (unit_cnt == TIMEOUT_UNIT_CYC - 1) begin
               unit_cnt <= 32'h0;
               if (unit_num + 7'h01 >= chan_wdog[7:1]) begin
                  chan_abort <= 1'b1;
                  txn_busy   <= 1'b0;
               end else begin
                  unit_num <= unit_num + 7'h01;
               end
            end else begin
               unit_cnt <= unit_cnt + 32'h1;
            end
         end
      end
   end

   // Pin synchronisers
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
      end
   end

   // Glitch filter: at 50 ns per cycle any depth up to 75 ns fits in
   // two cycles, so a change must stand depth/50 + 1 cycles
   logic [3:0] filt_need;
   logic [3:0] scl_cnt;
   logic [3:0] sda_cnt;
   logic       sda_clean;

   assign filt_need = 4'((i2c_timing[3:0] * `FILTER_UNIT_NS) /
                         `CLK_PERIOD_NS + 1);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_filt  <= 1'b1;
         sda_clean <= 1'b1;
         scl_cnt   <= 4'h0;
         sda_cnt   <= 4'h0;
      end else begin
         if (scl_sync[1] == scl_filt) begin
            scl_cnt <= 4'h0;
         end else if (scl_cnt + 4'h1 >= filt_need) begin
            scl_filt <= scl_sync[1];
            scl_cnt  <= 4'h0;
         end else begin
            scl_cnt <= scl_cnt + 4'h1;
         end
         if (sda_sync[1] == sda_clean) begin
            sda_cnt <= 4'h0;
         end else if (sda_cnt + 4'h1 >= filt_need) begin
            sda_clean <= sda_sync[1];
            sda_cnt   <= 4'h0;
         end else begin
            sda_cnt <= sda_cnt + 4'h1;
         end
      end
   end

   // SDA input hold: after an SCL fall, keep the old SDA for the hold time
   logic       scl_prev;
   logic [2:0] hold_cnt;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_prev <= 1'b1;
         hold_cnt <= 3'h0;
         sda_filt <= 1'b1;
      end else begin
         scl_prev <= scl_filt;
         if (scl_prev && !scl_filt) begin
            hold_cnt <= 3'(i2c_timing[6:4] * HOLD_CYC);
         end else if (hold_cnt != 3'h0) begin
            hold_cnt <= hold_cnt - 3'h1;
         end else begin
            sda_filt <= sda_clean;
         end
      end
   end

   // SDA output delay from SCL fall
   logic [3:0] dly_cnt;
   logic       sda_drv;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_cnt <= 4'h0;
         sda_drv <= 1'b0;
      end else if (scl_prev && !scl_filt) begin
         dly_cnt <= 4'(DBASE_CYC + err_wdog[4:3] * DSTEP_CYC);
         // A delay as long as the SCL period ends on the next fall
         if (dly_cnt == 4'h1) begin
            sda_drv <= sda_drive_req;
         end
      end else if (dly_cnt > 4'h1) begin
         dly_cnt <= dly_cnt - 4'h1;
      end else begin
         dly_cnt <= 4'h0;
         sda_drv <= sda_drive_req;
      end
   end

   // Bus watchdog
   ctl_chan_pkg::bus_state_e bus_state;
   logic [31:0] quiet_cnt;
   logic [31:0] quiet_lim;
   logic        activity;
   logic [4:0]  pulse_num;
   logic [7:0]  half_cnt;
   logic        sda_prev;

   assign quiet_lim = err_wdog[`BIT_BUS_WDOG_FAST] ?
                      BUS_FAST_CYC : BUS_SLOW_CYC;
   assign activity  = (scl_prev != scl_filt) || (sda_prev != sda_filt);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state <= ctl_chan_pkg::BUS_IDLE;
         quiet_cnt <= 32'h0;
         pulse_num <= 5'h0;
         half_cnt  <= 8'h0;
         sda_prev  <= 1'b1;
         scl_out   <= 1'b1;
         scl_oe    <= 1'b0;
         bus_free  <= 1'b0;
      end else begin
         sda_prev <= sda_filt;
         case (bus_state)
            ctl_chan_pkg::BUS_IDLE: begin
               scl_oe <= 1'b0;
               if (activity || err_wdog[`BIT_BUS_WDOG_OFF]) begin
                  quiet_cnt <= 32'h0;
                  bus_free  <= 1'b0;
               end else if (quiet_cnt >= quiet_lim - 1) begin
                  quiet_cnt <= 32'h0;
                  if (sda_filt) begin
                     bus_free  <= 1'b1;
                     bus_state <= ctl_chan_pkg::BUS_FREE;
                  end else begin
                     pulse_num <= 5'h0;
                     half_cnt  <= 8'h0;
                     bus_state <= ctl_chan_pkg::BUS_RECOVER;
                  end
               end else begin
                  quiet_cnt <= quiet_cnt + 32'h1;
               end
            end
            ctl_chan_pkg::BUS_RECOVER: begin
               // Enable follows the level being set, never pulls a high
               if (half_cnt == 8'(PULSE_HALF_CYC - 1)) begin
                  half_cnt <= 8'h0;
                  scl_oe   <= scl_out;
                  scl_out  <= !scl_out;
                  if (!scl_out) begin
                     if (pulse_num == 5'(`RECOVER_PULSES - 1)) begin
                        bus_state <= ctl_chan_pkg::BUS_IDLE;
                     end
                     pulse_num <= pulse_num + 5'h1;
                  end
               end else begin
                  half_cnt <= half_cnt + 8'h1;
                  scl_oe   <= !scl_out;
               end
            end
            ctl_chan_pkg::BUS_FREE: begin
               if (activity || err_wdog[`BIT_BUS_WDOG_OFF]) begin
                  bus_free  <= 1'b0;
                  bus_state <= ctl_chan_pkg::BUS_IDLE;
               end
            end
            default: bus_state <= ctl_chan_pkg::BUS_IDLE;
         endcase
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = sda_drv && (bus_state != ctl_chan_pkg::BUS_RECOVER);

endmodule
`default_nettype wire

// File: verif/ctl_chan_props.sv
// Port-level assertions for the control channel supervisor
`timescale 1ns/10ps
`default_nettype none
module ctl_chan_props #(
   parameter int unsigned PULSE_HALF_CYC = 4
) (
   input wire logic                       sys_clk,    // Clock
   input wire logic                       rst_n,      // Reset, low
   input wire ctl_chan_pkg::reg_req_s     req,        // Register access
   input wire logic                 [7:0] rdata,      // Read data
   input wire logic                       wr_refused, // Write dropped
   input wire ctl_chan_pkg::chan_status_s chan,       // Channel status
   input wire logic                       scl_out,    // SCL value
   input wire logic                       scl_oe,     // SCL enable
   input wire logic                       txn_valid,  // Transaction
   input wire logic                       alias_hit,  // Alias hit
   input wire logic                 [6:0] alias_phys, // Physical addr
   input wire logic                 [6:0] txn_addr,   // Txn address
   input wire logic                       fwd_txn,    // Forwarded
   input wire logic                 [6:0] fwd_addr,   // Forward addr
   input wire logic                       chan_abort, // Abort pulse
   input wire logic                       bus_free    // Bus free
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   int unsigned oe_run;
   // Length of the current SCL low drive, to judge each low half of recovery
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) oe_run <= 0;
      else oe_run <= scl_oe ? oe_run + 1 : 0;
   end
   AST_REFUSE: assert property (wr_refused |-> req.wr && req.remote)
      else $error("refusal without a remote write");
   AST_FWD_CAUSE: assert property (fwd_txn |-> $past(txn_valid))
      else $error("forward without a transaction");
   AST_FWD_ALIAS: assert property (fwd_txn && $past(alias_hit) |->
      fwd_addr == $past(alias_phys)) else $error("alias not remapped");
   AST_FWD_RAW: assert property (fwd_txn && !$past(alias_hit) |->
      fwd_addr == $past(txn_addr)) else $error("address altered");
   AST_ABORT_ONCE: assert property (chan_abort |=> !chan_abort)
      else $error("abort longer than one cycle");
   AST_ABORT_EARLY: assert property (chan.start |=> !chan_abort [*8])
      else $error("abort right after start");
   AST_SCL_LOW: assert property (scl_oe |-> !scl_out)
      else $error("SCL driven high");
   AST_PULSE_LEN: assert property ($fell(scl_oe) |-> oe_run == PULSE_HALF_CYC)
      else $error("recovery pulse of wrong length");
   AST_FREE_QUIET: assert property (bus_free |-> !scl_oe)
      else $error("recovery while bus free");
   AST_SEQ_SEEN: assert property (chan.seq_err ##1 req.addr == 8'h06 |-> rdata[7])
      else $error("sequence error not flagged");
endmodule
bind ctl_chan_supervisor ctl_chan_props #(.PULSE_HALF_CYC(PULSE_HALF_CYC))
   props_u (.sys_clk, .rst_n, .req, .rdata, .wr_refused, .chan, .scl_out,
   .scl_oe, .txn_valid, .alias_hit, .alias_phys, .txn_addr, .fwd_txn,
   .fwd_addr, .chan_abort, .bus_free);
`default_nettype wire

// File: verif/far_side_model.sv
// Remote serializer status and a local bus talker on open-drain pins
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
   input  wire logic                         sys_clk, // System clock
   output var ctl_chan_pkg::chan_status_s    chan,    // Channel status
   output logic                              scl_drv, // 0 pulls SCL low
   output logic                              sda_drv  // 0 pulls SDA low
);
   initial begin
      chan = '0;
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   // One-cycle event: 0 start, 1 done, else sequence error
   task automatic pulse(input int k);
      @(posedge sys_clk);
      case (k)
         0: chan.start <= 1'b1;
         1: chan.done <= 1'b1;
         default: chan.seq_err <= 1'b1;
      endcase
      @(posedge sys_clk);
      {chan.start, chan.done, chan.seq_err} <= 3'b000;
   endtask
   task automatic link(input logic up, input logic [6:0] id);
      @(posedge sys_clk);
      chan.lock <= up;
      chan.far_id <= id;
   endtask
   // Nine 400 ns SCL periods; SCL stands high between frames
   task automatic frame();
      #7;
      repeat (9) begin
         #200 scl_drv = 1'b0;
         #200 scl_drv = 1'b1;
      end
   endtask
   task automatic hold_sda(input int n);
      @(posedge sys_clk);
      sda_drv <= 1'b0;
      repeat (n) @(posedge sys_clk);
      sda_drv <= 1'b1;
   endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the control channel supervisor
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int UNIT = 20;
   localparam int FAST = 50;
   localparam int SLOW = 200;
   logic                       sys_clk = 1'b0;
   logic                       rst_n = 1'b0;
   ctl_chan_pkg::reg_req_s     req = '0;
   ctl_chan_pkg::chan_status_s chan;
   logic                       txn_valid;
   logic                       addr_match;
   logic                       alias_hit;
   logic                 [6:0] alias_phys;
   logic                 [6:0] txn_addr;
   logic                       sda_drive_req = 1'b0;
   logic                 [7:0] rdata, v;
   logic                 [6:0] fwd_addr, id;
   logic                       wr_refused, scl_out, scl_oe, sda_out, sda_oe;
   logic                       fwd_txn, chan_abort, scl_filt, sda_filt;
   logic                       bus_free, scl_drv, sda_drv, got, p;
   int                         n_mismatch = 0;
   int                         num_checks = 0;
   int                         seed = 28044;
   int                         n, k, t;
   logic                 [1:0] f;
   wire logic scl_in = scl_drv & ~(scl_oe & ~scl_out);
   wire logic sda_in = sda_drv & ~(sda_oe & ~sda_out);
   always #25 sys_clk = ~sys_clk;
   ctl_chan_supervisor #(.TIMEOUT_UNIT_CYC(UNIT), .BUS_FAST_CYC(FAST),
      .BUS_SLOW_CYC(SLOW), .PULSE_HALF_CYC(4)) dut_u (.sys_clk, .rst_n,
      .req, .rdata, .wr_refused, .chan, .scl_in, .sda_in, .scl_out, .scl_oe,
      .sda_out, .sda_oe, .sda_drive_req, .txn_valid, .addr_match,
      .alias_hit, .alias_phys, .txn_addr, .fwd_txn, .fwd_addr, .chan_abort,
      .scl_filt, .sda_filt, .bus_free);
   far_side_model far_u (.sys_clk, .chan, .scl_drv, .sda_drv);
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic ck(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rm);
      @(posedge sys_clk);
      req <= '{1'b1, 1'b0, rm, a, d};
      @(negedge sys_clk);
      got = wr_refused;
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      req <= '{1'b0, 1'b1, 1'b0, a, 8'h00};
      @(negedge sys_clk);
      ck(rdata, e);
   endtask
   task automatic fw(input logic [6:0] ta, input logic ah,
                     input logic [6:0] ap, input logic m, input logic e);
      @(posedge sys_clk);
      txn_valid <= 1'b1;
      txn_addr <= ta;
      alias_hit <= ah;
      alias_phys <= ap;
      addr_match <= m;
      @(posedge sys_clk);
      txn_valid <= 1'b0;
      @(negedge sys_clk);
      ck({7'h00, fwd_txn}, {7'h00, e});
      if (e) ck({1'b0, fwd_addr}, {1'b0, ah ? ap : ta});
   endtask
   // Watched output: 0 abort, 1 bus free, 2 SCL drive, 3 SCL low, 4 SDA drive
   function automatic logic seen(input int s);
      logic [4:0] w;
      w = {sda_oe, ~scl_filt, scl_oe, bus_free, chan_abort};
      seen = w[s];
   endfunction
   // Counts cycles until the chosen output rises; a must-wait that
   // runs out ends the run, since nothing after it can be trusted
   task automatic till(input int s, input int lim, input logic must);
      n = 0;
      while (n < lim && seen(s) !== 1'b1) begin
         @(negedge sys_clk);
         n++;
      end
      if (must && seen(s) !== 1'b1) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   initial begin
      {txn_valid, addr_match, alias_hit, alias_phys, txn_addr} <= '0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rc(8'h04, 8'hfe);
      rc(8'h05, 8'h1e);
      rc(8'h06, 8'h00);
      rc(8'h07, 8'h00);
      rc(8'h20, 8'h00);
      far_u.hold_sda(1);
      repeat (6) begin
         @(negedge sys_clk);
         ck({7'h00, sda_filt}, 8'h01);
      end
      far_u.hold_sda(6);
      @(negedge sys_clk);
      ck({7'h00, sda_filt}, 8'h00);
      v = 8'($random(seed));
      wr(8'h05, v, 1'b0);
      rc(8'h05, v);
      wr(8'h06, 8'ha0, 1'b0);
      rc(8'h06, 8'h00);
      far_u.pulse(2);
      rc(8'h06, 8'h80);
      wr(8'h06, 8'h40, 1'b0);
      rc(8'h06, 8'h40);
      wr(8'h06, 8'h04, 1'b0);
      wr(8'h05, ~v, 1'b1);
      ck({7'h00, got}, 8'h01);
      rc(8'h05, v);
      wr(8'h05, 8'h9e, 1'b0);
      fw(7'h21, 1'b0, 7'h00, 1'b0, 1'b1);
      wr(8'h06, 8'h00, 1'b0);
      wr(8'h05, 8'h9e, 1'b1);
      ck({7'h00, got}, 8'h00);
      fw(7'h00, 1'b0, 7'h00, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         fw(7'h08 | 7'($random(seed)), i[0], 7'($random(seed)), 1'b0, 1'b1);
      end
      wr(8'h05, 8'h1e, 1'b0);
      fw(7'h11, 1'b0, 7'h00, 1'b1, 1'b0);
      wr(8'h03, 8'h08, 1'b0);
      fw(7'h11, 1'b1, 7'h35, 1'b0, 1'b0);
      fw(7'h11, 1'b1, 7'h35, 1'b1, 1'b1);
      id = 7'($random(seed));
      far_u.link(1'b1, id);
      repeat (3) @(posedge sys_clk);
      rc(8'h07, {id, 1'b0});
      wr(8'h07, {~id, 1'b1}, 1'b0);
      rc(8'h07, {~id, 1'b1});
      far_u.link(1'b0, id);
      t = 1 + {$random(seed)} % 3;
      wr(8'h04, {t[6:0], 1'b0}, 1'b0);
      far_u.pulse(0);
      till(0, 5 * UNIT, 1'b1);
      ck({7'h00, n >= t * UNIT - 1 && n <= t * UNIT + 2}, 8'h01);
      far_u.pulse(0);
      repeat (UNIT / 2) @(posedge sys_clk);
      far_u.pulse(1);
      till(0, 5 * UNIT, 1'b0);
      ck(n[7:0], 8'(5 * UNIT));
      wr(8'h04, {t[6:0], 1'b1}, 1'b0);
      far_u.pulse(0);
      till(0, 5 * UNIT, 1'b0);
      ck(n[7:0], 8'(5 * UNIT));
      f = 2'($random(seed));
      wr(8'h06, {3'b000, f, 3'b000}, 1'b0);
      // Drive request raised just after the first filtered SCL fall
      fork
         far_u.frame();
         begin
            till(3, 40, 1'b1);
            @(posedge sys_clk);
            sda_drive_req <= 1'b1;
            till(4, 20, 1'b1);
            ck({7'h00, n >= 5 + f && n <= 7 + f}, 8'h01);
            @(posedge sys_clk);
            sda_drive_req <= 1'b0;
         end
      join
      wr(8'h06, 8'h02, 1'b0);
      far_u.frame();
      till(1, 3 * FAST, 1'b1);
      ck({7'h00, n >= FAST && n <= FAST + 8}, 8'h01);
      wr(8'h06, 8'h00, 1'b0);
      fork
         far_u.hold_sda(SLOW + 120);
         begin
            till(2, 2 * SLOW, 1'b1);
            ck({7'h00, n >= SLOW + 4 && n <= SLOW + 14}, 8'h01);
            k = 1;
            p = 1'b1;
            repeat (100) begin
               @(negedge sys_clk);
               if (scl_oe === 1'b1 && p === 1'b0) k++;
               p = scl_oe;
            end
            ck(k[7:0], 8'h09);
         end
      join
      finish_test();
   end
endmodule
`default_nettype wire
